// >>> hw/bdm_defs.vh
`ifndef BDM_DEFS_VH
`define BDM_DEFS_VH

// ****************************************************************
// Core register offsets, valid in every bank.
// ****************************************************************
`define BDM_OFF_IND0      7'h00
`define BDM_OFF_IND1      7'h01
`define BDM_OFF_PC_LOW    7'h02
`define BDM_OFF_STAT      7'h03
`define BDM_OFF_PTR0_LO   7'h04
`define BDM_OFF_PTR0_HI   7'h05
`define BDM_OFF_PTR1_LO   7'h06
`define BDM_OFF_PTR1_HI   7'h07
`define BDM_OFF_BANK_SEL  7'h08
`define BDM_OFF_WORK      7'h09
`define BDM_OFF_PC_LATCH  7'h0A
`define BDM_OFF_INT_CTL   7'h0B

// ****************************************************************
// Bank-relative regions.
// ****************************************************************
`define BDM_CORE_LAST     7'h0B
`define BDM_SFR_FIRST     7'h0C
`define BDM_SFR_LAST      7'h1F
`define BDM_GPR_FIRST     7'h20
`define BDM_GPR_LAST      7'h6F
`define BDM_COMMON_FIRST  7'h70
`define BDM_GPR_PER_BANK  12'h050
`define BDM_GPR_BANKS     5'h18
`define BDM_REMAP_FIRST   5'h1B
`define BDM_REMAP_LAST    5'h1D

// ****************************************************************
// Linear window and storage sizes.
// ****************************************************************
`define BDM_LIN_BASE      16'h2000
`define BDM_LIN_SIZE      16'h0780
`define BDM_COMMON_BASE   11'h780
`define BDM_RAM_WORDS     1936

// ****************************************************************
// Reset values and fields.
// ****************************************************************
`define BDM_RST_PC_LOW    8'h00
`define BDM_RST_STAT      5'h18
`define BDM_RST_PTR       8'h00
`define BDM_RST_BANK_SEL  5'h00
`define BDM_RST_WORK      8'h00
`define BDM_RST_PC_LATCH  7'h00
`define BDM_RST_INT_CTL   3'h1
`define BDM_STAT_WR_MASK  5'h07
`define BDM_INT_GIE_BIT   7
`define BDM_INT_PEIE_BIT  6
`define BDM_INT_EDGE_BIT  0

`endif

// >>> hw/bdm_ptr_pair.v
`include "bdm_defs.vh"

// ****************************************************************
// Indirect pointer pair: low and high byte of one data address.
// ****************************************************************
module bdm_ptr_pair (
   input  wire        ref_clk,
   input  wire        rstSyncN,
   input  wire        wrLow,
   input  wire        wrHigh,
   input  wire [7:0]  wrData,
   output wire [15:0] ptrValue
);

   reg [7:0] lowByte_ff;
   reg [7:0] highByte_ff;

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         lowByte_ff  <= `BDM_RST_PTR;
         highByte_ff <= `BDM_RST_PTR;
      end else begin
         if (wrLow) begin
            lowByte_ff <= wrData;
         end
         if (wrHigh) begin
            highByte_ff <= wrData;
         end
      end
   end

   assign ptrValue = {highByte_ff, lowByte_ff};

endmodule

// >>> hw/bdm_core_regs.v
`include "bdm_defs.vh"

// Notes on behaviour
// - Core offsets 00h-0Bh same in every bank.
// - Twenty-byte peripheral window at 0Ch-1Fh.
// - Banks 27-29 hold remap and logic-cell registers.
// - Up to 80 general RAM bytes per bank.
// - General RAM also reachable linearly via pointers.
// - Sixteen common RAM bytes shared by all banks.
// - Indirect ports access memory at pointer address.
// - Upper counter bits load on low-byte write.
module bdm_core_regs (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire [6:0]  memAddr,
   input  wire        memWrEn,
   input  wire        memRdEn,
   input  wire [7:0]  memWrData,
   output reg  [7:0]  memRdData,
   output reg         memRdValid,
   input  wire        pcStep,
   output wire [14:0] programCounter,
   output wire        sfrSel,
   output wire        remapSel,
   output wire [11:0] periphAddr,
   output wire        periphWrEn,
   output wire [7:0]  periphWrData,
   input  wire [7:0]  periphRdData,
   output wire        globalIntEnable,
   output wire        periphIntEnable,
   output wire        intEdgeRising
);

   // ****************************************************************
   // Reset release.
   // ****************************************************************
   reg        rstMeta_ff;
   reg        rstSyncN;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_ff <= 1'b0;
         rstSyncN   <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSyncN   <= rstMeta_ff;
      end
   end

   // ****************************************************************
   // State.
   // ****************************************************************
   reg  [7:0]  pcLow_ff;
   reg  [6:0]  pcHigh_ff;
   reg  [4:0]  status_ff;
   reg  [4:0]  bankSel_ff;
   reg  [7:0]  work_ff;
   reg  [6:0]  pcLatch_ff;
   reg  [2:0]  intCtl_ff;
   reg  [7:0]  ram [0:`BDM_RAM_WORDS-1];
   wire [15:0] ptr0;
   wire [15:0] ptr1;

   // ****************************************************************
   // Address resolution.
   // ****************************************************************
   reg  [15:0] effAddr;
   reg         isTrad;
   reg  [6:0]  tOff;
   reg  [4:0]  tBank;
   reg         remapBank;
   reg         isCore;
   reg         isSfr;
   reg         isRemap;
   reg         isRam;
   reg  [11:0] idx12;
   reg  [15:0] linOff;
   reg  [7:0]  coreRd;
   reg  [15:0] nxt_pc;

   always @* begin
      if (memAddr == `BDM_OFF_IND0) begin
         effAddr = ptr0;
      end else if (memAddr == `BDM_OFF_IND1) begin
         effAddr = ptr1;
      end else begin
         effAddr = {4'h0, bankSel_ff, memAddr};
      end
      isTrad    = (effAddr[15:12] == 4'h0);
      tOff      = effAddr[6:0];
      tBank     = effAddr[11:7];
      remapBank = (tBank >= `BDM_REMAP_FIRST) &&
                  (tBank <= `BDM_REMAP_LAST);
      isCore    = isTrad && (tOff <= `BDM_CORE_LAST) &&
                  (tOff > `BDM_OFF_IND1);
      isSfr     = isTrad && !remapBank && (tOff >= `BDM_SFR_FIRST) &&
                  (tOff <= `BDM_SFR_LAST);
      isRemap   = isTrad && remapBank && (tOff >= `BDM_SFR_FIRST) &&
                  (tOff <= `BDM_GPR_LAST);
      linOff    = effAddr - `BDM_LIN_BASE;
      isRam     = 1'b0;
      idx12     = 12'h000;
      if (isTrad && (tOff >= `BDM_COMMON_FIRST)) begin
         isRam = 1'b1;
         idx12 = {1'b0, `BDM_COMMON_BASE} + {8'h00, tOff[3:0]};
      end else if (isTrad && (tOff >= `BDM_GPR_FIRST) &&
                   (tOff <= `BDM_GPR_LAST) &&
                   (tBank < `BDM_GPR_BANKS)) begin
         isRam = 1'b1;
         idx12 = {7'h00, tBank} * `BDM_GPR_PER_BANK +
                 {5'h00, tOff} - {5'h00, `BDM_GPR_FIRST};
      end else if ((effAddr >= `BDM_LIN_BASE) &&
                   (linOff < `BDM_LIN_SIZE)) begin
         isRam = 1'b1;
         idx12 = linOff[11:0];
      end
   end

   assign sfrSel       = (memWrEn || memRdEn) && isSfr;
   assign remapSel     = (memWrEn || memRdEn) && isRemap;
   assign periphAddr   = effAddr[11:0];
   assign periphWrEn   = memWrEn && (isSfr || isRemap);
   assign periphWrData = memWrData;

   // ****************************************************************
   // Core register read mux.
   // ****************************************************************
   always @* begin
      case (tOff)
         `BDM_OFF_PC_LOW:   coreRd = pcLow_ff;
         `BDM_OFF_STAT:     coreRd = {3'h0, status_ff};
         `BDM_OFF_PTR0_LO:  coreRd = ptr0[7:0];
         `BDM_OFF_PTR0_HI:  coreRd = ptr0[15:8];
         `BDM_OFF_PTR1_LO:  coreRd = ptr1[7:0];
         `BDM_OFF_PTR1_HI:  coreRd = ptr1[15:8];
         `BDM_OFF_BANK_SEL: coreRd = {3'h0, bankSel_ff};
         `BDM_OFF_WORK:     coreRd = work_ff;
         `BDM_OFF_PC_LATCH: coreRd = {1'b0, pcLatch_ff};
         `BDM_OFF_INT_CTL:  coreRd = {intCtl_ff[2:1], 5'h00,
                                     intCtl_ff[0]};
         default:           coreRd = 8'h00;
      endcase
   end

   // ****************************************************************
   // Pointer pairs.
   // ****************************************************************
   wire coreWr = memWrEn && isCore;

   bdm_ptr_pair uPtr0 (
      .ref_clk  (ref_clk),
      .rstSyncN (rstSyncN),
      .wrLow    (coreWr && (tOff == `BDM_OFF_PTR0_LO)),
      .wrHigh   (coreWr && (tOff == `BDM_OFF_PTR0_HI)),
      .wrData   (memWrData),
      .ptrValue (ptr0)
   );

   bdm_ptr_pair uPtr1 (
      .ref_clk  (ref_clk),
      .rstSyncN (rstSyncN),
      .wrLow    (coreWr && (tOff == `BDM_OFF_PTR1_LO)),
      .wrHigh   (coreWr && (tOff == `BDM_OFF_PTR1_HI)),
      .wrData   (memWrData),
      .ptrValue (ptr1)
   );

   // ****************************************************************
   // Core registers.
   // ****************************************************************
   always @* begin
      nxt_pc = {1'b0, pcHigh_ff, pcLow_ff} + 16'h0001;
   end

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pcLow_ff   <= `BDM_RST_PC_LOW;
         pcHigh_ff  <= 7'h00;
         status_ff  <= `BDM_RST_STAT;
         bankSel_ff <= `BDM_RST_BANK_SEL;
         work_ff    <= `BDM_RST_WORK;
         pcLatch_ff <= `BDM_RST_PC_LATCH;
         intCtl_ff  <= `BDM_RST_INT_CTL;
      end else begin
         if (coreWr && (tOff == `BDM_OFF_PC_LOW)) begin
            pcLow_ff  <= memWrData;
            pcHigh_ff <= pcLatch_ff;
         end else if (pcStep) begin
            pcLow_ff  <= nxt_pc[7:0];
            pcHigh_ff <= nxt_pc[14:8];
         end
         if (coreWr) begin
            case (tOff)
               `BDM_OFF_STAT: begin
                  status_ff <= (status_ff & ~`BDM_STAT_WR_MASK) |
                               (memWrData[4:0] & `BDM_STAT_WR_MASK);
               end
               `BDM_OFF_BANK_SEL: begin
                  bankSel_ff <= memWrData[4:0];
               end
               `BDM_OFF_WORK: begin
                  work_ff <= memWrData;
               end
               `BDM_OFF_PC_LATCH: begin
                  pcLatch_ff <= memWrData[6:0];
               end
               `BDM_OFF_INT_CTL: begin
                  intCtl_ff <= {memWrData[`BDM_INT_GIE_BIT],
                                memWrData[`BDM_INT_PEIE_BIT],
                                memWrData[`BDM_INT_EDGE_BIT]};
               end
               default: begin
                  work_ff <= work_ff;
               end
            endcase
         end
      end
   end

   assign programCounter  = {pcHigh_ff, pcLow_ff};
   assign globalIntEnable = intCtl_ff[2];
   assign periphIntEnable = intCtl_ff[1];
   assign intEdgeRising   = intCtl_ff[0];

   // ****************************************************************
   // Data RAM and read return.
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (memWrEn && isRam) begin
         ram[idx12[10:0]] <= memWrData;
      end
   end

   always @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         memRdData  <= 8'h00;
         memRdValid <= 1'b0;
      end else begin
         memRdValid <= memRdEn;
         if (memRdEn) begin
            if (isRam) begin
               memRdData <= ram[idx12[10:0]];
            end else if (isCore) begin
               memRdData <= coreRd;
            end else if (isSfr || isRemap) begin
               memRdData <= periphRdData;
            end else begin
               memRdData <= 8'h00;
            end
         end
      end
   end

endmodule

// >>> sim/bdm_periph_model.sv
// ****************************************
// Peripheral and remap register responder.
// ****************************************
module bdm_periph_model (
   input  logic        ref_clk,
   input  logic        sfrSel,
   input  logic        remapSel,
   input  logic [11:0] periphAddr,
   input  logic        periphWrEn,
   input  logic [7:0]  periphWrData,
   output logic [7:0]  periphRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] regFile [0:4095];
   logic [7:0] lastRd_ff = 8'h00;
   always @(posedge ref_clk) begin
      if (periphWrEn) regFile[periphAddr] <= periphWrData;
      lastRd_ff <= periphRdData;
   end
   // Unselected space shows a changing pattern, never a held value.
   assign periphRdData = (sfrSel | remapSel) ? regFile[periphAddr]
                                             : ~lastRd_ff;
endmodule

// >>> sim/bdm_core_regs_asserts.sv
// ****************************************
// Port checker for the core register block.
// ****************************************
module bdm_core_regs_asserts (
   input logic        ref_clk,
   input logic        rst_n,
   input logic [6:0]  memAddr,
   input logic        memWrEn,
   input logic        memRdEn,
   input logic [7:0]  memWrData,
   input logic [7:0]  memRdData,
   input logic        memRdValid,
   input logic        pcStep,
   input logic [14:0] programCounter,
   input logic        sfrSel,
   input logic        remapSel,
   input logic [11:0] periphAddr,
   input logic        periphWrEn,
   input logic [7:0]  periphWrData,
   input logic        globalIntEnable,
   input logic        periphIntEnable,
   input logic        intEdgeRising
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Shadows of the bank select and the counter latch, kept from writes.
   logic [4:0] bankShadow_ff;
   logic [6:0] latchShadow_ff;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bankShadow_ff  <= 5'h00;
         latchShadow_ff <= 7'h00;
      end else if (memWrEn && memAddr == 7'h08) begin
         bankShadow_ff <= memWrData[4:0];
      end else if (memWrEn && memAddr == 7'h0A) begin
         latchShadow_ff <= memWrData[6:0];
      end
   end
   a_read_answer: assert property (memRdEn |=> memRdValid)
      else $error("read without answer");
   a_sfr_window: assert property (
      sfrSel && memAddr > 7'h01 |->
      memAddr >= 7'h0C && memAddr <= 7'h1F &&
      !(periphAddr[11:7] inside {[5'h1B:5'h1D]}))
      else $error("peripheral window misdecoded");
   a_remap_bank: assert property (
      remapSel && memAddr > 7'h01 |->
      periphAddr[11:7] inside {[5'h1B:5'h1D]})
      else $error("remap select outside remap banks");
   a_direct_addr: assert property (
      (memWrEn || memRdEn) && memAddr inside {[7'h0C:7'h6F]} |->
      periphAddr == {bankShadow_ff, memAddr})
      else $error("direct address wrong");
   a_periph_wr: assert property (
      periphWrEn |-> memWrEn && periphWrData == memWrData)
      else $error("peripheral write without core write");
   a_pc_load: assert property (
      memWrEn && memAddr == 7'h02 |=>
      programCounter[7:0] == $past(memWrData))
      else $error("counter low byte not loaded");
   a_pc_upper: assert property (
      memWrEn && memAddr == 7'h02 |=>
      programCounter[14:8] == latchShadow_ff)
      else $error("counter upper bits not taken from latch");
   a_pc_step: assert property (
      pcStep && !(memWrEn && memAddr == 7'h02)
      |=> programCounter == $past(programCounter) + 15'h0001)
      else $error("counter did not step");
   a_wr_visible: assert property (
      memWrEn && memAddr == 7'h09 ##1 memRdEn && memAddr == 7'h09
      |=> memRdData == $past(memWrData, 2))
      else $error("accumulator write not seen");
   a_int_bits: assert property (
      memWrEn && memAddr == 7'h0B |=>
      {globalIntEnable, periphIntEnable, intEdgeRising} ==
      {$past(memWrData[7]), $past(memWrData[6]), $past(memWrData[0])})
      else $error("interrupt control bits wrong");
endmodule
bind bdm_core_regs bdm_core_regs_asserts chkr (.ref_clk(ref_clk),
   .rst_n(rst_n), .memAddr(memAddr), .memWrEn(memWrEn),
   .memRdEn(memRdEn), .memWrData(memWrData), .memRdData(memRdData),
   .memRdValid(memRdValid), .pcStep(pcStep),
   .programCounter(programCounter), .sfrSel(sfrSel),
   .remapSel(remapSel), .periphAddr(periphAddr),
   .periphWrEn(periphWrEn), .periphWrData(periphWrData),
   .globalIntEnable(globalIntEnable), .periphIntEnable(periphIntEnable),
   .intEdgeRising(intEdgeRising));

// >>> sim/bdm_core_regs_bench.sv
// ****************************************
// Self-checking bench for the core registers.
// ****************************************
module bdm_core_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [6:0]  memAddr = 7'h00;
   logic        memWrEn = 1'b0;
   logic        memRdEn = 1'b0;
   logic [7:0]  memWrData = 8'h00;
   logic        pcStep = 1'b0;
   wire  [7:0]  memRdData, periphWrData, periphRdData;
   wire         memRdValid, sfrSel, remapSel, periphWrEn;
   wire         gie, pie, ied;
   wire  [14:0] programCounter;
   wire  [11:0] periphAddr;
   int          errors = 0;
   int          samples_checked = 0;
   integer      seed = 46733;
   logic [7:0]  expQ[$];
   logic [7:0]  v;
   int          b, o, n, i;
   logic [7:0]  rstVal [12] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
   logic [6:0]  wa [4] = '{7'h03, 7'h08, 7'h0A, 7'h0B};
   logic [7:0]  we [4] = '{8'h1F, 8'h1F, 8'h7F, 8'hC1};
   always #12.5 ref_clk = ~ref_clk;
   bdm_core_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .memAddr(memAddr),
      .memWrEn(memWrEn), .memRdEn(memRdEn), .memWrData(memWrData),
      .memRdData(memRdData), .memRdValid(memRdValid), .pcStep(pcStep),
      .programCounter(programCounter), .sfrSel(sfrSel),
      .remapSel(remapSel), .periphAddr(periphAddr),
      .periphWrEn(periphWrEn), .periphWrData(periphWrData),
      .periphRdData(periphRdData), .globalIntEnable(gie),
      .periphIntEnable(pie), .intEdgeRising(ied));
   bdm_periph_model partner (.ref_clk(ref_clk), .sfrSel(sfrSel),
      .remapSel(remapSel), .periphAddr(periphAddr),
      .periphWrEn(periphWrEn), .periphWrData(periphWrData),
      .periphRdData(periphRdData));
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
      memWrEn <= w;
      memRdEn <= ~w;
      memAddr <= a;
      memWrData <= d;
      @(posedge ref_clk);
   endtask
   task automatic rd(logic [6:0] a, logic [7:0] e);
      expQ.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   task automatic final_report();
      if (errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (memRdValid === 1'b1) begin
         if (expQ.size() == 0) begin
            chk("spare answer", 16'h0001, 16'h0000);
         end else begin
            chk("read data", {8'h00, memRdData}, {8'h00, expQ[0]});
            void'(expQ.pop_front());
         end
      end
   end
   initial begin
      #100000;
      errors++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (i = 2; i < 12; i++) rd(i[6:0], rstVal[i]);
      for (i = 0; i < 4; i++) begin
         acc(1'b1, wa[i], 8'hFF);
         rd(wa[i], we[i]);
      end
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         acc(1'b1, 7'h08, 8'(8 * i + 1));
         acc(1'b1, 7'h09, v);
         rd(7'h09, v);
         acc(1'b1, 7'h08, 8'(31 - i));
         rd(7'h09, v);
         acc(1'b1, 7'h0B, v);
      end
      for (i = 0; i < 6; i++) begin
         b = (i == 0) ? 23 : {$random(seed)} % 24;
         o = (i == 0) ? 79 : {$random(seed)} % 80;
         n = b * 80 + o;
         v = $random(seed);
         acc(1'b1, 7'h08, b[7:0]);
         acc(1'b1, 7'h20 + o[6:0], v);
         acc(1'b1, 7'h04, n[7:0]);
         acc(1'b1, 7'h05, 8'h20 + n[15:8]);
         rd(7'h00, v);
         acc(1'b1, 7'h06, n[7:0]);
         acc(1'b1, 7'h07, 8'h20 + n[15:8]);
         acc(1'b1, 7'h01, ~v);
         rd(7'h20 + o[6:0], ~v);
      end
      acc(1'b1, 7'h08, 8'h18);
      acc(1'b1, 7'h20, 8'hAA);
      rd(7'h20, 8'h00);
      acc(1'b1, 7'h08, 8'h03);
      acc(1'b1, 7'h7F, v);
      acc(1'b1, 7'h08, 8'h11);
      rd(7'h7F, v);
      acc(1'b1, 7'h08, 8'h02);
      acc(1'b1, 7'h10, v);
      rd(7'h10, v);
      acc(1'b1, 7'h08, 8'h1C);
      acc(1'b1, 7'h21, ~v);
      rd(7'h21, ~v);
      acc(1'b1, 7'h0A, 8'h5A);
      acc(1'b1, 7'h02, 8'hFE);
      memWrEn <= 1'b0;
      memRdEn <= 1'b0;
      @(posedge ref_clk);
      chk("counter load", {1'b0, programCounter}, 16'h5AFE);
      pcStep <= 1'b1;
      repeat (3) @(posedge ref_clk);
      pcStep <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("counter step", {1'b0, programCounter}, 16'h5B01);
      pcStep <= 1'b1;
      acc(1'b1, 7'h02, 8'h10);
      pcStep <= 1'b0;
      memWrEn <= 1'b0;
      @(posedge ref_clk);
      chk("load beats step", {1'b0, programCounter}, 16'h5A10);
      chk("answers left", 16'(expQ.size()), 16'h0000);
      final_report();
   end
endmodule
